/* hw/mfr_dev.sv */
// Flash-side multi-lane read engine with continuous mode and wrap bursts
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "mfr_map.svh"
module mfr_dev #(
    parameter int MEM_AW = 8
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    mfr_if.dev LNK,
    input wire logic QE_IN,
    input wire logic MEM_WR_IN,
    input wire logic [MEM_AW-1:0] MEM_ADDR_IN,
    input wire logic [7:0] MEM_DATA_IN,
    output logic CONT_MODE_OUT,
    output logic [2:0] WRAP_SETTING_OUT,
    output logic BUSY_OUT
);
    logic [5:0] pin_s;
    logic sck_s;
    logic cs_n_s;
    logic [3:0] io_s;
    logic sck_q;
    logic rise;
    logic fall;
    mfr_pkg::mfr_dev_state_t st_q;
    logic [7:0] op_q;
    logic [7:0] cont_op_q;
    logic cont_q;
    logic [2:0] wrap_q;
    logic [31:0] sh_q;
    logic [31:0] sh_in;
    logic [4:0] cnt_q;
    logic [23:0] addr_q;
    logic [23:0] addr_nx;
    logic [23:0] inc;
    logic [7:0] mask;
    logic [7:0] osh_q;
    logic [1:0] ucnt_q;
    logic [3:0] io_o_q;
    logic [3:0] io_oe_q;
    logic started_q;
    logic busy_q;
    logic quad_w;
    logic ddr_w;
    logic in_evt;
    logic out_evt;
    logic unit_last;
    logic [4:0] addr_units;
    logic [4:0] mode_units;
    logic mode_done;
    logic [7:0] mem_q [0:(1<<MEM_AW)-1];
    logic [7:0] byte_w;

    // Link clock is sampled like any other pin
    mfr_sync #(.W(6), .RST(6'h10)) u_sync (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .d_in({LNK.sck, LNK.cs_n, LNK.io}),
        .q_out(pin_s)
    );
    assign sck_s = pin_s[5];
    assign cs_n_s = pin_s[4];
    assign io_s = pin_s[3:0];
    assign rise = sck_s & ~sck_q;
    assign fall = ~sck_s & sck_q;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            sck_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            sck_q <= sck_s;
            busy_q <= ~cs_n_s;
        end
    end

    assign quad_w = (op_q != `MFR_OP_DUAL_DDR); // [RULE9] [RULE10]
    assign ddr_w = (op_q == `MFR_OP_DUAL_DDR) || (op_q == `MFR_OP_QUAD_DDR);
    assign addr_units = quad_w ? 5'd6 : 5'd12; // [RULE1]
    assign mode_units = quad_w ? 5'd2 : 5'd4;

    // Address and mode move on both edges in double-rate reads
    assign in_evt = (st_q == mfr_pkg::DS_OPC) ? rise
        : (rise | (fall & ddr_w)); // [RULE17]

    always_comb begin
        if (st_q == mfr_pkg::DS_OPC) begin
            sh_in = {sh_q[30:0], io_s[0]};
        end else if (quad_w) begin
            sh_in = {sh_q[27:0], io_s};
        end else begin
            sh_in = {sh_q[29:0], io_s[1:0]}; // [RULE1]
        end
    end

    assign mode_done = (st_q == mfr_pkg::DS_MODE) && in_evt && (cnt_q == mode_units - 5'd1);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            sh_q <= 32'h0000_0000;
        end else if (in_evt && (st_q == mfr_pkg::DS_OPC || st_q == mfr_pkg::DS_ADDR
                || st_q == mfr_pkg::DS_MODE)) begin
            sh_q <= sh_in;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            st_q <= mfr_pkg::DS_IDLE;
            cnt_q <= 5'h00;
            op_q <= 8'h00;
        end else if (cs_n_s) begin
            st_q <= mfr_pkg::DS_IDLE;
            cnt_q <= 5'h00;
        end else begin
            unique case (st_q)
                mfr_pkg::DS_IDLE: begin
                    cnt_q <= 5'h00;
                    if (cont_q) begin
                        // Address comes at once, eight clocks saved
                        op_q <= cont_op_q; // [RULE3]
                        st_q <= mfr_pkg::DS_ADDR;
                    end else begin
                        st_q <= mfr_pkg::DS_OPC; // [RULE4]
                    end
                end
                mfr_pkg::DS_OPC: begin
                    if (in_evt) begin
                        cnt_q <= cnt_q + 5'd1;
                        if (cnt_q == 5'd7) begin
                            cnt_q <= 5'h00;
                            op_q <= sh_in[7:0];
                            if (sh_in[7:0] == `MFR_OP_DUAL_DDR) begin
                                st_q <= mfr_pkg::DS_ADDR; // [RULE1]
                            end else if (QE_IN && (sh_in[7:0] == `MFR_OP_QUAD_SDR
                                    || sh_in[7:0] == `MFR_OP_QUAD_DDR
                                    || sh_in[7:0] == `MFR_OP_SET_WRAP)) begin
                                st_q <= mfr_pkg::DS_ADDR; // [RULE11]
                            end else begin
                                st_q <= mfr_pkg::DS_IGNORE;
                            end
                        end
                    end
                end
                mfr_pkg::DS_ADDR: begin
                    if (in_evt) begin
                        cnt_q <= cnt_q + 5'd1;
                        if (cnt_q == addr_units - 5'd1) begin
                            cnt_q <= 5'h00;
                            st_q <= mfr_pkg::DS_MODE;
                        end
                    end
                end
                mfr_pkg::DS_MODE: begin
                    if (in_evt) begin
                        cnt_q <= cnt_q + 5'd1;
                    end
                    if (mode_done) begin
                        cnt_q <= 5'h00;
                        st_q <= (op_q == `MFR_OP_SET_WRAP) ? mfr_pkg::DS_IGNORE
                            : mfr_pkg::DS_DUMMY;
                    end
                end
                mfr_pkg::DS_DUMMY: begin
                    if (rise) begin
                        cnt_q <= cnt_q + 5'd1;
                        if (cnt_q == `MFR_DUMMY_CLKS - 5'd1) begin
                            st_q <= mfr_pkg::DS_DATA; // [RULE9] [RULE10]
                        end
                    end
                end
                mfr_pkg::DS_DATA: begin
                    st_q <= mfr_pkg::DS_DATA;
                end
                mfr_pkg::DS_IGNORE: begin
                    st_q <= mfr_pkg::DS_IGNORE;
                end
                default: begin
                    st_q <= mfr_pkg::DS_IGNORE;
                end
            endcase
        end
    end

    // Continuous state is held across deselect; reset or a read's mode byte without bits 10 clears it
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            cont_q <= 1'b0; // [RULE18]
            cont_op_q <= 8'h00;
            wrap_q <= `MFR_WRAP_RST; // [RULE16]
        end else if (mode_done) begin
            if (op_q == `MFR_OP_SET_WRAP) begin
                wrap_q <= sh_in[6:4]; // [RULE12] [RULE15]
            end else begin
                // Lower nibble is not looked at
                cont_q <= (sh_in[5:4] == `MFR_CONT_KEEP); // [RULE2] [RULE3] [RULE4]
                cont_op_q <= op_q;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (MEM_WR_IN) begin
            mem_q[MEM_ADDR_IN] <= MEM_DATA_IN;
        end
    end

    assign byte_w = mem_q[addr_q[MEM_AW-1:0]];
    assign inc = addr_q + 24'h00_0001;
    assign mask = (8'h08 << wrap_q[2:1]) - 8'h01; // [RULE13] [RULE16]
    // Wrap only for quad reads with the disable bit clear
    assign addr_nx = (quad_w && !wrap_q[0])
        ? {addr_q[23:8], (addr_q[7:0] & ~mask) | (inc[7:0] & mask)} // [RULE14]
        : inc; // [RULE19]

    // First data unit goes out on a falling edge, then both edges if double-rate
    assign out_evt = (st_q == mfr_pkg::DS_DATA) && (fall || (rise && ddr_w && started_q));
    assign unit_last = quad_w ? (ucnt_q == 2'd1) : (ucnt_q == 2'd3);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || cs_n_s) begin
            io_o_q <= 4'h0;
            io_oe_q <= 4'h0;
            started_q <= 1'b0;
            ucnt_q <= 2'd0;
            osh_q <= 8'h00;
            if (!RST_N_IN) begin
                addr_q <= 24'h00_0000;
            end
        end else if (st_q == mfr_pkg::DS_MODE && cnt_q == 5'h00 && in_evt) begin
            addr_q <= sh_q[23:0];
        end else if (out_evt) begin
            started_q <= 1'b1;
            io_oe_q <= quad_w ? 4'hF : 4'h3; // [RULE9] [RULE1]
            ucnt_q <= unit_last ? 2'd0 : ucnt_q + 2'd1;
            if (ucnt_q == 2'd0) begin
                io_o_q <= quad_w ? byte_w[7:4] : {2'b00, byte_w[7:6]};
                osh_q <= quad_w ? {byte_w[3:0], 4'h0} : {byte_w[5:0], 2'b00};
                addr_q <= addr_nx;
            end else begin
                io_o_q <= quad_w ? osh_q[7:4] : {2'b00, osh_q[7:6]};
                osh_q <= quad_w ? {osh_q[3:0], 4'h0} : {osh_q[5:0], 2'b00};
            end
        end
    end

    assign LNK.d_io_o = io_o_q;
    assign LNK.d_io_oe = io_oe_q;
    assign CONT_MODE_OUT = cont_q;
    assign WRAP_SETTING_OUT = wrap_q;
    assign BUSY_OUT = busy_q;
endmodule : mfr_dev

/* hw/mfr_host.sv */
// Host-side controller: issues multi-lane reads from a small register set
`timescale 1ns/1ps
`include "mfr_map.svh"
module mfr_host #(
    parameter int SCK_HALF = `MFR_SCK_HALF
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    mfr_if.host LNK,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT
);
    mfr_pkg::mfr_host_state_t st_q;
    logic [31:0] cmd_q;
    logic [23:0] adr_q;
    logic [15:0] cnt_q;
    logic tick_e;
    logic tick_m;
    logic [3:0] io_s;
    logic sck_q;
    logic cs_n_q;
    logic [3:0] io_q;
    logic [3:0] oe_q;
    logic [31:0] tx_q;
    logic [7:0] left_q;
    logic [7:0] rxb_q;
    logic [1:0] bc_q;
    logic [31:0] rxw_q;
    logic [7:0] rcnt_q;
    logic quad;
    logic ddr;
    logic smp;
    logic go;
    logic byte_end;

    mfr_sync #(.W(4), .RST(4'hF)) u_sync (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .d_in(LNK.io),
        .q_out(io_s)
    );

    assign quad = cmd_q[`MFR_CMD_QUAD];
    assign ddr = cmd_q[`MFR_CMD_DDR];
    assign tick_e = (cnt_q == 16'(SCK_HALF - 1));
    assign tick_m = (cnt_q == 16'(SCK_HALF / 2 - 1));
    assign go = REG_WR_IN && (REG_ADDR_IN == `MFR_REG_GO) && (st_q == mfr_pkg::HS_IDLE);
    // Sampling edge coming up: rising, or both edges past the opcode in double-rate
    assign smp = ~sck_q | (ddr & (st_q != mfr_pkg::HS_OPC)); // [RULE17]
    assign byte_end = quad ? (bc_q == 2'd1) : (bc_q == 2'd3);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || st_q == mfr_pkg::HS_IDLE || tick_e) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Settings are frozen while a frame runs
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            cmd_q <= 32'h0000_0000;
            adr_q <= 24'h00_0000;
        end else if (REG_WR_IN && st_q == mfr_pkg::HS_IDLE) begin
            if (REG_ADDR_IN == `MFR_REG_CMD) begin
                cmd_q <= REG_WDATA_IN;
            end
            if (REG_ADDR_IN == `MFR_REG_ADDR) begin
                adr_q <= REG_WDATA_IN[23:0];
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            st_q <= mfr_pkg::HS_IDLE;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
            io_q <= 4'h0;
            oe_q <= 4'h0;
            tx_q <= 32'h0000_0000;
            left_q <= 8'h00;
            rxb_q <= 8'h00;
            bc_q <= 2'd0;
            rxw_q <= 32'h0000_0000;
            rcnt_q <= 8'h00;
        end else begin
            unique case (st_q)
                mfr_pkg::HS_IDLE: begin
                    if (go) begin
                        cs_n_q <= 1'b0;
                        rcnt_q <= 8'h00;
                        bc_q <= 2'd0;
                        if (cmd_q[`MFR_CMD_SKIP]) begin
                            // Mode byte of all ones forces the exit from continuous reads
                            tx_q <= {adr_q, cmd_q[31:24]}; // [RULE5] [RULE6] [RULE7]
                            left_q <= quad ? 8'd6 : 8'd12;
                            st_q <= mfr_pkg::HS_ADDR;
                        end else begin
                            tx_q <= {cmd_q[7:0], 24'h00_0000};
                            left_q <= 8'd8;
                            st_q <= mfr_pkg::HS_OPC;
                        end
                    end
                end
                mfr_pkg::HS_OPC, mfr_pkg::HS_ADDR, mfr_pkg::HS_MODE: begin
                    // New bits half way through the phase, well clear of the edge
                    if (tick_m && smp) begin
                        if (st_q == mfr_pkg::HS_OPC) begin
                            oe_q <= 4'h1;
                            io_q <= {3'b000, tx_q[31]};
                            tx_q <= {tx_q[30:0], 1'b0};
                        end else if (quad) begin
                            oe_q <= 4'hF;
                            io_q <= tx_q[31:28];
                            tx_q <= {tx_q[27:0], 4'h0};
                        end else begin
                            oe_q <= 4'h3;
                            io_q <= {2'b00, tx_q[31:30]};
                            tx_q <= {tx_q[29:0], 2'b00};
                        end
                    end
                    if (tick_e) begin
                        sck_q <= ~sck_q;
                        if (smp) begin
                            left_q <= left_q - 8'd1;
                            if (left_q == 8'd1) begin
                                if (st_q == mfr_pkg::HS_OPC) begin
                                    tx_q <= {adr_q, cmd_q[31:24]};
                                    left_q <= quad ? 8'd6 : 8'd12;
                                    st_q <= mfr_pkg::HS_ADDR;
                                end else if (st_q == mfr_pkg::HS_ADDR) begin
                                    left_q <= quad ? 8'd2 : 8'd4;
                                    st_q <= mfr_pkg::HS_MODE;
                                end else begin
                                    left_q <= {4'h0, cmd_q[15:12]};
                                    st_q <= mfr_pkg::HS_DUM;
                                end
                            end
                        end
                    end
                end
                mfr_pkg::HS_DUM: begin
                    if (tick_m) begin
                        oe_q <= 4'h0; // [RULE8]
                    end
                    if (tick_e) begin
                        sck_q <= ~sck_q;
                        if (!sck_q && left_q != 8'd0) begin
                            left_q <= left_q - 8'd1;
                        end
                        if (sck_q && left_q == 8'd0) begin
                            left_q <= cmd_q[23:16];
                            st_q <= (cmd_q[23:16] == 8'h00) ? mfr_pkg::HS_END
                                : mfr_pkg::HS_DATA;
                        end
                    end
                end
                mfr_pkg::HS_DATA: begin
                    if (tick_e) begin
                        sck_q <= ~sck_q;
                        if (smp) begin
                            rxb_q <= quad ? {rxb_q[3:0], io_s} : {rxb_q[5:0], io_s[1:0]};
                            bc_q <= byte_end ? 2'd0 : bc_q + 2'd1;
                            if (byte_end) begin
                                rxw_q <= {rxw_q[23:0],
                                    (quad ? {rxb_q[3:0], io_s} : {rxb_q[5:0], io_s[1:0]})};
                                rcnt_q <= rcnt_q + 8'd1;
                                left_q <= left_q - 8'd1;
                                if (left_q == 8'd1) begin
                                    st_q <= mfr_pkg::HS_END;
                                    sck_q <= 1'b0;
                                end
                            end
                        end
                    end
                end
                mfr_pkg::HS_END: begin
                    if (tick_e) begin
                        if (sck_q) begin
                            sck_q <= 1'b0;
                        end else begin
                            cs_n_q <= 1'b1;
                            st_q <= mfr_pkg::HS_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= mfr_pkg::HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || !REG_RD_IN) begin
            REG_RDATA_OUT <= 32'h0000_0000;
        end else begin
            unique case (REG_ADDR_IN)
                `MFR_REG_CMD: REG_RDATA_OUT <= cmd_q;
                `MFR_REG_ADDR: REG_RDATA_OUT <= {8'h00, adr_q};
                `MFR_REG_GO: REG_RDATA_OUT <= {16'h0000, rcnt_q, 7'h00,
                    st_q != mfr_pkg::HS_IDLE};
                `MFR_REG_RX: REG_RDATA_OUT <= rxw_q;
                default: REG_RDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    assign LNK.sck = sck_q;
    assign LNK.cs_n = cs_n_q;
    assign LNK.h_io_o = io_q;
    assign LNK.h_io_oe = oe_q;
endmodule : mfr_host

/* hw/mfr_if.sv */
// Serial link between host controller and flash read engine
`timescale 1ns/1ps
interface mfr_if;
    logic sck;
    logic cs_n;
    logic [3:0] h_io_o;
    logic [3:0] h_io_oe;
    logic [3:0] d_io_o;
    logic [3:0] d_io_oe;
    logic [3:0] io;

    // Undriven lanes float high as through pull-ups
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io[i] = d_io_oe[i] ? d_io_o[i] : (h_io_oe[i] ? h_io_o[i] : 1'b1);
        end
    end

    modport dev (input sck, input cs_n, input io, output d_io_o, output d_io_oe);
    modport host (output sck, output cs_n, output h_io_o, output h_io_oe, input io);
endinterface : mfr_if

/* hw/mfr_map.svh */
// Opcodes, field positions, reset values and counts of the multi-lane read engine
//
// Operation
// RULE1 - Dual double-rate opcode: two-lane address, two-lane data
// RULE2 - Upper mode nibble decides opcode; lower ignored
// RULE3 - Mode bits 10: next frame skips opcode
// RULE4 - Other mode bits: next frame needs opcode
// RULE5 - Dual double-rate exit: ones on lane0
// RULE6 - Quad single-rate exit: ones for eight clocks
// RULE7 - Quad double-rate exit: ones on lane0
// RULE8 - Host releases lanes before first data edge
// RULE9 - Quad opcode: four lanes, four dummy clocks
// RULE10 - Quad double-rate: four lanes, four dummies, wrap
// RULE11 - Quad commands only with quad lane enable
// RULE12 - Stored wrap setting governs later quad reads
// RULE13 - Wrap section 8 to 64 bytes, aligned
// RULE14 - Wrapped burst restarts at section start
// RULE15 - Three wrap bits: disable and length
// RULE16 - Disable bit one at reset; lengths 8..64
// RULE17 - Double-rate moves bits on both edges
// RULE18 - Continuous state survives deselect, cleared by reset
// RULE19 - Unwrapped reads increment address each byte
`ifndef MFR_MAP_SVH
`define MFR_MAP_SVH

`define MFR_OP_DUAL_DDR 8'hBD
`define MFR_OP_QUAD_SDR 8'hEB
`define MFR_OP_QUAD_DDR 8'hED
`define MFR_OP_SET_WRAP 8'h77
`define MFR_CONT_KEEP 2'h2
`define MFR_DUMMY_CLKS 5'h04
`define MFR_WRAP_RST 3'h1
`define MFR_SCK_HALF 8

`define MFR_REG_CMD 4'h0
`define MFR_REG_ADDR 4'h4
`define MFR_REG_GO 4'h8
`define MFR_REG_RX 4'hC

`define MFR_CMD_QUAD 8
`define MFR_CMD_DDR 9
`define MFR_CMD_SKIP 10

`endif

/* hw/mfr_pkg.sv */
// State types of both ends of the multi-lane read link
package mfr_pkg;
    typedef enum logic [2:0] {
        DS_IDLE, DS_OPC, DS_ADDR, DS_MODE, DS_DUMMY, DS_DATA, DS_IGNORE
    } mfr_dev_state_t;
    typedef enum logic [2:0] {
        HS_IDLE, HS_OPC, HS_ADDR, HS_MODE, HS_DUM, HS_DATA, HS_END
    } mfr_host_state_t;
endpackage : mfr_pkg

/* hw/mfr_sync.sv */
// Two-flop synchroniser for pins from another clock domain
`timescale 1ns/1ps
module mfr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= RST;
            q_out <= RST;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule : mfr_sync

/* tb/mfr_sva.sv */
// Link checks between the host and flash ends
`timescale 1ns/1ps
module mfr_sva (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] h_io_oe,
    input wire logic [3:0] d_io_oe
);
    logic sck_q;
    logic [7:0] edge_q;
    always_ff @(posedge CLK_IN) begin
        sck_q <= sck;
    end
    // Saturates so long bursts never fall back under the limit
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || cs_n) begin
            edge_q <= 8'h00;
        end else if (sck && !sck_q && edge_q != 8'hFF) begin
            edge_q <= edge_q + 8'h01;
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    no_contention_a: assert property (!(|(h_io_oe & d_io_oe)))
        else $error("host and device drive one lane");
    dev_lanes_a: assert property (d_io_oe inside {4'h0, 4'h3, 4'hF})
        else $error("device lane enables malformed");
    host_lanes_a: assert property (h_io_oe inside {4'h0, 4'h1, 4'h3, 4'hF})
        else $error("host lane enables malformed");
    dev_early_a: assert property ((|d_io_oe) && !cs_n |-> edge_q >= 8'h08)
        else $error("device drives before dummies end");
    dev_hold_a: assert property ((|d_io_oe) && !cs_n ##1 !cs_n |-> $stable(d_io_oe))
        else $error("device lanes dropped mid burst");
    dev_release_a: assert property ($rose(cs_n) |-> ##[1:4] d_io_oe == 4'h0)
        else $error("device kept lanes after deselect");
    rst_idle_a: assert property ($rose(RST_N_IN) |-> cs_n && !sck && h_io_oe == 4'h0)
        else $error("link not idle after reset");
    sck_frame_a: assert property ($changed(sck) |-> !cs_n || !$past(cs_n))
        else $error("serial clock moved outside frame");
endmodule : mfr_sva

/* tb/mfr_tb_top.sv */
// Bench joining host and flash ends over one link
`timescale 1ns/1ps
`include "mfr_map.svh"
module multi_io_fast_read_engine_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic qe = 1'b1;
    logic mwr = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] maddr = 8'h00;
    logic [7:0] mdata = 8'h00;
    logic [3:0] raddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic cont;
    logic busy;
    logic [2:0] wrap;
    int n_mismatch = 0;
    int checked = 0;
    mfr_if lnk ();
    mfr_dev mfr_dev_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .LNK(lnk.dev), .QE_IN(qe),
        .MEM_WR_IN(mwr), .MEM_ADDR_IN(maddr), .MEM_DATA_IN(mdata), .CONT_MODE_OUT(cont),
        .WRAP_SETTING_OUT(wrap), .BUSY_OUT(busy));
    mfr_host mfr_host_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .LNK(lnk.host),
        .REG_ADDR_IN(raddr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata));
    mfr_sva mfr_sva_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .sck(lnk.sck), .cs_n(lnk.cs_n),
        .h_io_oe(lnk.h_io_oe), .d_io_oe(lnk.d_io_oe));
    initial begin
        forever #4 clk = ~clk;
    end
    function automatic logic [7:0] mv(input logic [7:0] a);
        return a + 8'h3C;
    endfunction : mv
    // Four bytes newest last; sz zero means no wrap
    function automatic logic [31:0] exp4(input logic [7:0] a, input logic [7:0] sz);
        logic [31:0] r;
        logic [7:0] b;
        r = 32'h0;
        for (int i = 0; i < 4; i++) begin
            b = (sz == 8'h00) ? a + i[7:0] : (a & ~(sz - 8'h01)) | ((a + i[7:0]) & (sz - 8'h01));
            r = {r[23:0], mv(b)};
        end
        return r;
    endfunction : exp4
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        raddr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        raddr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    // Flags are {skip, double-rate, quad}
    task automatic frame(input logic [7:0] op, input logic [2:0] fl, input logic [7:0] md,
        input logic [7:0] a, input logic [7:0] n, input logic [3:0] dm, output logic [31:0] rx);
        logic [31:0] st;
        wreg(`MFR_REG_CMD, {md, n, dm, 1'b0, fl, op});
        wreg(`MFR_REG_ADDR, {24'h0, a});
        wreg(`MFR_REG_GO, 32'h1);
        // Select reaches the flash end through two sync flops
        repeat (4) @(posedge clk);
        chk("busy", 32'h1, {31'h0, busy});
        // Settings are frozen mid frame, so this write must be dropped
        wreg(`MFR_REG_ADDR, 32'h0);
        st = 32'h1;
        for (int i = 0; i < 4000 && st[0] !== 1'b0; i++) begin
            rreg(`MFR_REG_GO, st);
        end
        chk("done", 32'h0, {31'h0, st[0]});
        chk("count", {24'h0, n}, {24'h0, st[15:8]});
        rreg(`MFR_REG_RX, rx);
        chk("busy", 32'h0, {31'h0, busy});
        rreg(`MFR_REG_ADDR, st);
        chk("addr", {24'h0, a}, st);
    endtask : frame
    task automatic t_reset;
        chk("cont", 32'h0, {31'h0, cont});
        chk("wrap", 32'h1, {29'h0, wrap});
    endtask : t_reset
    task automatic t_cont;
        logic [7:0] ops [3] = '{`MFR_OP_DUAL_DDR, `MFR_OP_QUAD_SDR, `MFR_OP_QUAD_DDR};
        logic [2:0] fl [3] = '{3'h2, 3'h1, 3'h3};
        logic [31:0] rx;
        for (int k = 0; k < 3; k++) begin
            frame(ops[k], fl[k], 8'h2F, 8'h1E + k[7:0], 8'h04, 4'h4, rx);
            chk("rx", exp4(8'h1E + k[7:0], 8'h00), rx);
            chk("cont", 32'h1, {31'h0, cont});
            frame(ops[k], fl[k] | 3'h4, 8'hE5, 8'h90, 8'h04, 4'h4, rx);
            chk("rx", exp4(8'h90, 8'h00), rx);
            frame(ops[k], fl[k] | 3'h4, 8'hFF, 8'h00, 8'h00, 4'h4, rx);
            chk("cont", 32'h0, {31'h0, cont});
        end
    endtask : t_cont
    task automatic t_qe;
        logic [31:0] rx;
        @(posedge clk);
        qe <= 1'b0;
        frame(`MFR_OP_QUAD_SDR, 3'h1, 8'h20, 8'h50, 8'h04, 4'h4, rx);
        chk("rx", 32'hFFFFFFFF, rx);
        chk("cont", 32'h0, {31'h0, cont});
        @(posedge clk);
        qe <= 1'b1;
    endtask : t_qe
    task automatic t_wrap;
        logic [31:0] rx;
        logic [7:0] sz;
        for (int k = 0; k < 4; k++) begin
            sz = 8'h08 << k;
            frame(`MFR_OP_SET_WRAP, 3'h1, {1'b0, k[1:0], 5'h00}, 8'h00, 8'h00, 4'h0, rx);
            chk("wrap", {29'h0, k[1:0], 1'b0}, {29'h0, wrap});
            frame(k[0] ? `MFR_OP_QUAD_DDR : `MFR_OP_QUAD_SDR, {1'b0, k[0], 1'b1}, 8'h00,
                8'h40 + sz - 8'h02, 8'h04, 4'h4, rx);
            chk("rx", exp4(8'h40 + sz - 8'h02, sz), rx);
        end
        frame(`MFR_OP_SET_WRAP, 3'h1, 8'h70, 8'h00, 8'h00, 4'h0, rx);
        chk("wrap", 32'h7, {29'h0, wrap});
        frame(`MFR_OP_QUAD_DDR, 3'h3, 8'h00, 8'h7E, 8'h04, 4'h4, rx);
        chk("rx", exp4(8'h7E, 8'h00), rx);
        frame(`MFR_OP_QUAD_SDR, 3'h1, 8'h20, 8'h10, 8'h01, 4'h4, rx);
        chk("cont", 32'h1, {31'h0, cont});
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
    endtask : t_wrap
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        for (int a = 0; a < 256; a++) begin
            @(posedge clk);
            mwr <= 1'b1;
            maddr <= a[7:0];
            mdata <= mv(a[7:0]);
        end
        @(posedge clk);
        mwr <= 1'b0;
        t_cont();
        t_qe();
        t_wrap();
        results();
    end
    // Room for about ten times the expected run
    initial begin
        #640000;
        n_mismatch++;
        results();
    end
endmodule : multi_io_fast_read_engine_tb_top
